// [rtl/overlay_regs.v]
// overlay window position and swap control register bank, axi4-lite slave
// assumes one clock, synchronous reset, strap stable at reset release
//
// Our own choice: the AXI4-Lite slave port.
`include "overlay_regs_map.vh"
`default_nettype none

// Overview of operation
// - positions apply after y write, next vblank
// - x end in bits 25-16
// - x start in bits 9-0
// - x step by depth at 0/180
// - x steps one line at 90/270
// - y end 25-16, y start 9-0
// - y steps one line at 0/180
// - y step by depth at 90/270
// - horizontal extent up to 1024 pixels
// - vertical extent up to 1024 pixels
// - commit armed by endian-dependent byte write
// - blit port swaps bytes 0 and 1
// - word swap exchanges fetch halves
// - both swaps reverse all bytes
// - fetch and blit swaps act only in big-endian strap
// - byte swap exchanges byte pairs
// - latch select reverses y byte order
module overlay_regs
(
  input wire i_clk,
  input wire i_rst_n,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire i_endian_config_strap,
  input wire i_vblank,
  input wire [31:0] i_fetch_data,
  output reg [31:0] o_fetch_data,
  input wire [15:0] i_blit_wdata,
  output reg [15:0] o_blit_wdata,
  input wire [15:0] i_blit_rdata,
  output reg [15:0] o_blit_rdata,
  output reg [9:0] o_x_start,
  output reg [9:0] o_x_end,
  output reg [9:0] o_y_start,
  output reg [9:0] o_y_end,
  output reg [14:0] o_x_start_px,
  output reg [14:0] o_x_end_px,
  output reg [14:0] o_y_start_px,
  output reg [14:0] o_y_end_px,
  output reg o_extent_over
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [31:0] x_pos_q;
  reg [31:0] y_pos_q;
  reg [31:0] misc_q;
  reg [31:0] mode_q;
  reg big_endian_q;
  reg strap_taken_q;
  reg commit_pend_q;
  reg vblank_q;
  reg aw_full_q;
  reg w_full_q;
  reg [31:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;

  wire vblank_rise;
  wire do_write;
  wire [31:0] wdata_eff;
  wire [3:0] wstrb_eff;
  wire commit_byte;
  wire swap_en;
  wire [2:0] bpp;
  wire rot_quarter;
  wire [14:0] xs_px;
  wire [14:0] xe_px;
  wire [14:0] ys_px;
  wire [14:0] ye_px;
  wire xs_ov;
  wire xe_ov;
  wire ys_ov;
  wire ye_ov;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function [31:0] wmerge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    input [31:0] mask;
    integer i;
    reg [31:0] m;
    begin
      m = 32'h00000000;
      for (i = 0; i < 4; i = i + 1)
      begin
        m[i*8 +: 8] = {8{strb[i]}};
      end
      m = m & mask;
      wmerge = (old & ~m) | (data & m);
    end
  endfunction

  function [31:0] rev32;
    input [31:0] v;
    begin
      rev32 = {v[7:0], v[15:8], v[23:16], v[31:24]};
    end
  endfunction

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
  assign s_axi_wready = !w_full_q && !s_axi_bvalid;
  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 32'h00000000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_q[7:0])
          `OFS_X_POS, `OFS_Y_POS, `OFS_MISC, `OFS_STATUS, `OFS_MODE:
            s_axi_bresp <= (awaddr_q[31:8] == 24'h000000) ? 2'h0 : 2'h2;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // y register may be latched byte-reversed
  assign wdata_eff = (misc_q[`MISC_LATCH_REV] && awaddr_q[7:0] == `OFS_Y_POS) ?
    rev32(wdata_q) : wdata_q;
  assign wstrb_eff = (misc_q[`MISC_LATCH_REV] && awaddr_q[7:0] == `OFS_Y_POS) ?
    {wstrb_q[0], wstrb_q[1], wstrb_q[2], wstrb_q[3]} : wstrb_q;
  assign commit_byte = big_endian_q ? wstrb_q[0] : wstrb_q[3];

  // ----------------------------------------
  // registers, strap capture, commit
  // ----------------------------------------
  assign vblank_rise = i_vblank && !vblank_q;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      x_pos_q <= `RST_X_POS;
      y_pos_q <= `RST_Y_POS;
      misc_q <= `RST_MISC;
      mode_q <= `RST_MODE;
      big_endian_q <= 1'b0;
      strap_taken_q <= 1'b0;
      commit_pend_q <= 1'b0;
      vblank_q <= 1'b0;
    end
    else
    begin
      vblank_q <= i_vblank;
      if (!strap_taken_q)
      begin
        strap_taken_q <= 1'b1;
        big_endian_q <= i_endian_config_strap;
      end
      if (do_write && awaddr_q[31:8] == 24'h000000)
      begin
        case (awaddr_q[7:0])
          `OFS_X_POS: x_pos_q <= wmerge(x_pos_q, wdata_q, wstrb_q, `POS_WMASK);
          `OFS_Y_POS: y_pos_q <= wmerge(y_pos_q, wdata_eff, wstrb_eff, `POS_WMASK);
          `OFS_MISC: misc_q <= wmerge(misc_q, wdata_q, wstrb_q, `MISC_WMASK);
          `OFS_MODE: mode_q <= wmerge(mode_q, wdata_q, wstrb_q, `MODE_WMASK);
          default: mode_q <= mode_q;
        endcase
      end
      // arming write wins over a same-cycle commit
      if (do_write && awaddr_q == {24'h000000, `OFS_Y_POS} && commit_byte)
        commit_pend_q <= 1'b1;
      else if (commit_pend_q && vblank_rise)
        commit_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // active copies
  // ----------------------------------------
  assign bpp = mode_q[2:0];
  assign rot_quarter = mode_q[4];

  overlay_pos_scale u_xs (.i_units(x_pos_q[9:0]), .i_bpp(bpp),
    .i_pixel_axis(!rot_quarter), .o_value(xs_px), .o_over(xs_ov));
  overlay_pos_scale u_xe (.i_units(x_pos_q[25:16]), .i_bpp(bpp),
    .i_pixel_axis(!rot_quarter), .o_value(xe_px), .o_over(xe_ov));
  overlay_pos_scale u_ys (.i_units(y_pos_q[9:0]), .i_bpp(bpp),
    .i_pixel_axis(rot_quarter), .o_value(ys_px), .o_over(ys_ov));
  overlay_pos_scale u_ye (.i_units(y_pos_q[25:16]), .i_bpp(bpp),
    .i_pixel_axis(rot_quarter), .o_value(ye_px), .o_over(ye_ov));

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_x_start <= 10'h000;
      o_x_end <= 10'h000;
      o_y_start <= 10'h000;
      o_y_end <= 10'h000;
      o_x_start_px <= 15'h0000;
      o_x_end_px <= 15'h0000;
      o_y_start_px <= 15'h0000;
      o_y_end_px <= 15'h0000;
      o_extent_over <= 1'b0;
    end
    else if (commit_pend_q && vblank_rise)
    begin
      o_x_start <= x_pos_q[`POS_START_HI:`POS_START_LO];
      o_x_end <= x_pos_q[`POS_END_HI:`POS_END_LO];
      o_y_start <= y_pos_q[`POS_START_HI:`POS_START_LO];
      o_y_end <= y_pos_q[`POS_END_HI:`POS_END_LO];
      o_x_start_px <= xs_px;
      o_x_end_px <= xe_px;
      o_y_start_px <= ys_px;
      o_y_end_px <= ye_px;
      o_extent_over <= xs_ov | xe_ov | ys_ov | ye_ov;
    end
  end

  // ----------------------------------------
  // data swap paths
  // ----------------------------------------
  assign swap_en = big_endian_q;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_fetch_data <= 32'h00000000;
      o_blit_wdata <= 16'h0000;
      o_blit_rdata <= 16'h0000;
    end
    else
    begin
      case ({swap_en && misc_q[`MISC_WORD_SWAP], swap_en && misc_q[`MISC_BYTE_SWAP]})
        2'h1: o_fetch_data <= {i_fetch_data[23:16], i_fetch_data[31:24],
          i_fetch_data[7:0], i_fetch_data[15:8]};
        2'h2: o_fetch_data <= {i_fetch_data[15:0], i_fetch_data[31:16]};
        2'h3: o_fetch_data <= rev32(i_fetch_data);
        default: o_fetch_data <= i_fetch_data;
      endcase
      if (swap_en && misc_q[`MISC_BLIT_SWAP])
      begin
        o_blit_wdata <= {i_blit_wdata[7:0], i_blit_wdata[15:8]};
        o_blit_rdata <= {i_blit_rdata[7:0], i_blit_rdata[15:8]};
      end
      else
      begin
        o_blit_wdata <= i_blit_wdata;
        o_blit_rdata <= i_blit_rdata;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (s_axi_araddr[31:8] != 24'h000000)
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= 2'h2;
      end
      else
      begin
        case (s_axi_araddr[7:0])
          `OFS_X_POS: s_axi_rdata <= x_pos_q;
          `OFS_Y_POS: s_axi_rdata <= y_pos_q;
          `OFS_MISC: s_axi_rdata <= misc_q;
          `OFS_MODE: s_axi_rdata <= mode_q;
          `OFS_STATUS: s_axi_rdata <= {29'h0000000, o_extent_over, big_endian_q,
            commit_pend_q};
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // overlay_regs

`default_nettype wire

// [rtl/overlay_regs_map.vh]
// register offsets, field positions and reset values for the overlay
// position and swap register bank; included by the design files
`ifndef OVERLAY_REGS_MAP_VH
`define OVERLAY_REGS_MAP_VH

// ----------------------------------------
// offsets (byte addresses)
// ----------------------------------------
`define OFS_X_POS 8'h58
`define OFS_Y_POS 8'h5C
`define OFS_MISC 8'h60
`define OFS_STATUS 8'h64
`define OFS_MODE 8'h68

// ----------------------------------------
// fields
// ----------------------------------------
`define POS_END_HI 25
`define POS_END_LO 16
`define POS_START_HI 9
`define POS_START_LO 0
`define MISC_BLIT_SWAP 7
`define MISC_WORD_SWAP 6
`define MISC_BYTE_SWAP 5
`define MISC_LATCH_REV 2
`define MISC_RSVD_HI 23
`define MISC_RSVD_LO 16
`define MISC_WMASK 32'h000000E4
`define POS_WMASK 32'h03FF03FF
`define MODE_WMASK 32'h0000003F

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_X_POS 32'h00000000
`define RST_Y_POS 32'h00000000
`define RST_MISC 32'h00000000
`define RST_MODE 32'h00000000

// ----------------------------------------
// depth codes and extent limit
// ----------------------------------------
`define BPP_1 3'h0
`define BPP_2 3'h1
`define BPP_4 3'h2
`define BPP_8 3'h3
`define BPP_16 3'h4
`define MAX_EXTENT 11'h400

`endif

// [rtl/overlay_pos_scale.v]
// scales one shadowed position unit field to pixels or lines
// assumes depth codes and extent limit as in overlay_regs_map.vh
`include "overlay_regs_map.vh"
`default_nettype none

module overlay_pos_scale
(
  input wire [9:0] i_units,
  input wire [2:0] i_bpp,
  input wire i_pixel_axis,
  output wire [14:0] o_value,
  output wire o_over
);

  // ----------------------------------------
  // step per unit by depth
  // ----------------------------------------
  function [5:0] step;
    input [2:0] bpp;
    begin
      case (bpp)
        `BPP_1: step = 6'h20;
        `BPP_2: step = 6'h10;
        `BPP_4: step = 6'h08;
        `BPP_8: step = 6'h04;
        `BPP_16: step = 6'h02;
        default: step = 6'h02;
      endcase
    end
  endfunction

  wire [5:0] mult;
  wire [15:0] prod;

  assign mult = i_pixel_axis ? step(i_bpp) : 6'h01;
  assign prod = {6'h00, i_units} * {10'h000, mult};
  assign o_value = prod[14:0];
  assign o_over = (prod > {5'h00, `MAX_EXTENT});

endmodule // overlay_pos_scale

`default_nettype wire

// [testbench/overlay_regs_sva.sv]
// checker for the overlay register bank: handshakes, commit timing, swap bypass
// assumes the endian strap changes only while reset is low
`default_nettype none
module overlay_regs_sva
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic i_endian_config_strap,
  input wire logic i_vblank,
  input wire logic [31:0] i_fetch_data,
  input wire logic [31:0] o_fetch_data,
  input wire logic [9:0] o_x_start,
  input wire logic [9:0] o_y_end
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic [1:0] up_q;
  always_ff @(posedge i_clk)
    up_q <= !i_rst_n ? 2'h0 : (up_q == 2'h3 ? up_q : up_q + 2'h1);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  a_bvalid_cause: assert property ($rose(s_axi_bvalid) |->
    $past(s_axi_wvalid && s_axi_wready || s_axi_awvalid && s_axi_awready, 2))
    else $error("bvalid without a write");
  a_rvalid_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("rvalid without a read");
  a_commit_vblank: assert property ($changed(o_x_start) || $changed(o_y_end) |-> $past(i_vblank))
    else $error("active position moved outside vblank");
  a_fetch_bypass: assert property (up_q == 2'h3 && !i_endian_config_strap |=>
    o_fetch_data == $past(i_fetch_data))
    else $error("fetch altered in little endian");
endmodule // overlay_regs_sva
bind overlay_regs overlay_regs_sva chk (.*);
`default_nettype wire

// [testbench/overlay_host.sv]
// host processor model: axi4-lite master with write and read tasks
// assumes the slave answers each request; the bench bounds every wait
`default_nettype none
module overlay_host
(
  input wire logic i_clk,
  output var logic [31:0] s_axi_awaddr,
  output var logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output var logic [31:0] s_axi_wdata,
  output var logic [3:0] s_axi_wstrb,
  output var logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output var logic s_axi_bready,
  output var logic [31:0] s_axi_araddr,
  output var logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output var logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
      s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [1:0] r);
    @(posedge i_clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= a == 8'h60 ? d & 32'hFF00FFFF : d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge i_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge i_clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge i_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
endmodule // overlay_host
`default_nettype wire

// [testbench/overlay_position_and_swap_regs_test.sv]
// self-checking bench for the overlay register bank
// assumes overlay_regs and the host model; bench drives vblank, fetch and blit
`default_nettype none
module overlay_position_and_swap_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, dat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, o_extent_over;
  logic i_endian_config_strap = 1'b0;
  logic i_vblank = 1'b0;
  logic [31:0] i_fetch_data = 32'h0, o_fetch_data;
  logic [15:0] i_blit_wdata = 16'h0, i_blit_rdata = 16'h0, o_blit_wdata, o_blit_rdata;
  logic [9:0] o_x_start, o_x_end, o_y_start, o_y_end;
  logic [14:0] o_x_start_px, o_x_end_px, o_y_start_px, o_y_end_px;
  logic [31:0] ex [4] = '{32'h22114433, 32'h33441122, 32'h44332211, 32'h11223344};
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int f, xs, xe, ys, ye;
  overlay_regs dut (.*);
  overlay_host host (.*);
  always #20 i_clk = ~i_clk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    host.wr(a, d, s, rsp);
    chk("bresp", rsp, 0);
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, dat, rsp);
    chk("rdata", dat, e);
  endtask
  task automatic rst(input logic s);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    i_endian_config_strap <= s;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask
  task automatic vb;
    @(posedge i_clk);
    i_vblank <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_vblank <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    rst(1'b0);
    r(8'h58, 0);
    r(8'h60, 0);
    w(8'h58, 32'h01550123, 4'hF);
    w(8'h5C, 32'h02000010, 4'h7);
    vb();
    chk("ys", o_y_start, 0);
    w(8'h5C, 32'h02000010, 4'hF);
    r(8'h58, 32'h01550123);
    chk("xs", o_x_start, 0);
    vb();
    chk("xs", o_x_start, 10'h123);
    chk("xe", o_x_end, 10'h155);
    chk("ys", o_y_start, 10'h010);
    chk("ye", o_y_end, 10'h200);
    for (int k = 0; k < 10; k++)
    begin
      f = 32 >> (k % 5);
      w(8'h68, {27'h0, k > 4, 1'b0, 3'(k % 5)}, 4'hF);
      w(8'h5C, 32'h02000010, 4'h8);
      vb();
      xs = k > 4 ? 'h123 : 'h123 * f;
      xe = k > 4 ? 'h155 : 'h155 * f;
      ys = k > 4 ? 'h10 * f : 'h10;
      ye = k > 4 ? 'h200 * f : 'h200;
      chk("xsp", o_x_start_px, xs);
      chk("xep", o_x_end_px, xe);
      chk("ysp", o_y_start_px, ys);
      chk("yep", o_y_end_px, ye);
      chk("over", o_extent_over, xs > 1024 || xe > 1024 || ys > 1024 || ye > 1024);
    end
    w(8'h60, 32'hFFFFFFFF, 4'hF);
    r(8'h60, 32'h000000E4);
    i_fetch_data <= 32'h11223344;
    i_blit_wdata <= 16'hAABB;
    i_blit_rdata <= 16'hCCDD;
    repeat (2) @(posedge i_clk);
    chk("fetch", o_fetch_data, 32'h11223344);
    chk("blitw", o_blit_wdata, 16'hAABB);
    chk("blitr", o_blit_rdata, 16'hCCDD);
    host.rd(8'h70, dat, rsp);
    chk("rresp", rsp, 2);
    chk("rdata", dat, 0);
    rst(1'b1);
    w(8'h5C, 32'h01000000, 4'h8);
    vb();
    chk("ye", o_y_end, 0);
    for (int k = 0; k < 4; k++)
    begin
      w(8'h60, (k + 1) * 32, 4'hF);
      repeat (2) @(posedge i_clk);
      chk("fetch", o_fetch_data, ex[k]);
    end
    chk("blitw", o_blit_wdata, 16'hBBAA);
    chk("blitr", o_blit_rdata, 16'hDDCC);
    w(8'h60, 32'h04, 4'hF);
    w(8'h5C, 32'h10000002, 4'hF);
    vb();
    chk("ye", o_y_end, 10'h200);
    chk("ys", o_y_start, 10'h010);
    print_verdict();
  end
endmodule // overlay_position_and_swap_regs_test
`default_nettype wire
